// [design/clockgen_ctrl.sv]
/*
 Clock generator control: pin decode, output states,
 start-up and an I2C register slave.
 Assumes SCL as a clock port, SDA resolved outside,
 PLL lock on a plain input.
*/
`timescale 1ns/1ps
`default_nettype none
module clockgen_ctrl #(
  parameter int unsigned POR_CYCLES = clockgen_pkg::POR_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  scl_clk,
  input  wire logic                  serial_data_pin_in,
  output logic                       serial_data_pin_out,
  output logic                       serial_data_pin_oe_n,
  input  wire logic [1:0]            bank_a_select_hi,
  input  wire logic [1:0]            bank_a_select_lo,
  input  wire logic [1:0]            bank_b_select_hi,
  input  wire logic [1:0]            bank_b_select_lo,
  input  wire logic [1:0]            bank_c_select_hi,
  input  wire logic [1:0]            bank_c_select_lo,
  input  wire logic [1:0]            bank_d_select_hi,
  input  wire logic [1:0]            bank_d_select_lo,
  input  wire logic                  pll_locked_in,
  output logic [9:0]                 bank_a_ratio_x4,
  output logic [9:0]                 bank_b_ratio_x4,
  output logic [9:0]                 bank_c_ratio_x4,
  output logic [9:0]                 bank_d_ratio_x4,
  output logic [3:0]                 bank_pecl,
  output logic [1:0]                 bank_a_swing,
  output logic [1:0]                 bank_b_swing,
  output logic [1:0]                 bank_c_swing,
  output logic [1:0]                 bank_d_swing,
  output logic                       bank_d_frac,
  output logic                       bank_d_bypass,
  output logic [10:0]                diff_active,
  output logic [10:0]                diff_true,
  output logic [10:0]                diff_comp,
  output logic                       bank_d_single_active,
  output logic                       bank_d_single_out,
  output logic                       bank_d_single_oe_n,
  output logic                       pll_lock_enable,
  output logic                       lock_status,
  output logic                       serial_ready
);
  import clockgen_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Core domain: start-up sequence
  state_t             state_q;
  logic [POR_W-1:0]   por_cnt_q;
  logic               run;
  logic               por_done;

  assign run      = (state_q == ST_RUN);
  assign por_done = (por_cnt_q == POR_W'(POR_CYCLES - 1));

  // Power-on reset timer, then one configuration cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_POR;
      por_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_POR: begin
          por_cnt_q <= por_cnt_q + 1'b1;
          if (por_done) begin
            state_q <= ST_CFG;
          end
        end
        ST_CFG:  state_q <= ST_RUN;
        ST_RUN:  state_q <= ST_RUN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; straps may move any time
  logic [15:0] pins_s1_q;
  logic [15:0] pins_s2_q;
  logic        lock_s1_q;
  logic        lock_s2_q;
  logic        scl_s1_q;
  logic        scl_s2_q;
  logic        sda_s1_q;
  logic        sda_s2_q;
  logic        sda_p_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      scl_s1_q  <= 1'b1;
      scl_s2_q  <= 1'b1;
      sda_s1_q  <= 1'b1;
      sda_s2_q  <= 1'b1;
      sda_p_q   <= 1'b1;
    end else begin
      pins_s1_q <= {bank_d_select_hi, bank_d_select_lo, bank_c_select_hi, bank_c_select_lo,
                    bank_b_select_hi, bank_b_select_lo, bank_a_select_hi, bank_a_select_lo};
      pins_s2_q <= pins_s1_q;
      lock_s1_q <= pll_locked_in;
      lock_s2_q <= lock_s1_q;
      scl_s1_q  <= scl_clk;
      scl_s2_q  <= scl_s1_q;
      sda_s1_q  <= serial_data_pin_in;
      sda_s2_q  <= sda_s1_q;
      sda_p_q   <= sda_s2_q;
    end
  end

  // Three-level pin code: 00 low, 01 middle, 1x high
  function automatic logic [3:0] sel_idx(input logic [1:0] hi, input logic [1:0] lo);
    logic [3:0] h;
    logic [3:0] l;
    h = hi[1] ? 4'h2 : (hi[0] ? 4'h1 : 4'h0);
    l = lo[1] ? 4'h2 : (lo[0] ? 4'h1 : 4'h0);
    sel_idx = 4'((h << 1) + h + l);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register file, written through power-on reset and configuration and by STOP commit only
  logic [7:0]   regs_q [NUM_REGS];
  logic [7:0]   pend_q [NUM_REGS];
  logic [255:0] pend_v_q;
  logic [3:0]   idx [4];
  logic         start_det;
  logic         stop_det;

  assign start_det = scl_s2_q & sda_p_q & ~sda_s2_q;
  assign stop_det  = scl_s2_q & ~sda_p_q & sda_s2_q;

  // Pending bytes are stable here: SCL stands high once STOP is seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else if (state_q != ST_RUN) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= 8'h00;
      end
      regs_q[8'h01]      <= DEF_01;
      regs_q[8'h05]      <= DEF_05;
      regs_q[8'h08]      <= DEF_08;
      regs_q[REG_ENABLE] <= DEF_EN;
      if (state_q == ST_CFG) begin
        for (int b = 0; b < 4; b++) begin
          regs_q[BANK_BASE[b]] <= {4'h0, idx[b]};
        end
      end
    end else if (stop_det) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (pend_v_q[i]) begin
          regs_q[i] <= pend_q[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame control: the SCL domain is held in reset outside frames
  logic link_rst_q;
  logic start_seen_q;
  logic buf_clr_q;

  // Release only while SCL is low, so no SCL edge meets the release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_rst_q   <= 1'b1;
      start_seen_q <= 1'b0;
      buf_clr_q    <= 1'b1;
    end else if (!run) begin
      link_rst_q   <= 1'b1;
      start_seen_q <= 1'b0;
      buf_clr_q    <= 1'b1;
    end else if (stop_det) begin
      link_rst_q   <= 1'b1;
      start_seen_q <= 1'b0;
      buf_clr_q    <= 1'b1;
    end else if (start_det) begin
      link_rst_q   <= 1'b1;
      start_seen_q <= 1'b1;
      buf_clr_q    <= 1'b0;
    end else if (start_seen_q && !scl_s2_q) begin
      link_rst_q   <= 1'b0;
      start_seen_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // SCL domain: byte engine
  phase_t     phase_q;
  logic [3:0] cnt_q;
  logic [6:0] sr_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       ack_q;
  logic       first_q;
  logic       drive_low_q;
  logic       sda_o_q;
  logic [7:0] byte_w;
  logic       byte_end;
  logic       ack_clk;
  logic       rd_go;
  logic [7:0] regs_rd;

  assign byte_w   = {sr_q, serial_data_pin_in};
  assign byte_end = (cnt_q == 4'h7);
  assign ack_clk  = (cnt_q == 4'h8);
  assign rd_go    = ack_clk & (phase_q == PH_RD) & (first_q | ~serial_data_pin_in);
  // Registers move only at commit, so this read is quasi-static
  assign regs_rd  = regs_q[ptr_q];

  // Bits shift in on SCL rising; decisions made on the eighth bit
  always_ff @(posedge scl_clk or posedge link_rst_q) begin
    if (link_rst_q) begin
      phase_q <= PH_DEV;
      cnt_q   <= 4'h0;
      sr_q    <= 7'h00;
      tx_q    <= 8'h00;
      ack_q   <= 1'b0;
      first_q <= 1'b0;
    end else if (!ack_clk) begin
      cnt_q <= cnt_q + 4'h1;
      sr_q  <= byte_w[6:0];
      tx_q  <= {tx_q[6:0], 1'b0};
      if (byte_end) begin
        unique case (phase_q)
          PH_DEV: begin
            ack_q   <= (byte_w[7:1] == I2C_ADDR);
            first_q <= 1'b1;
            if (byte_w[7:1] != I2C_ADDR) begin
              phase_q <= PH_IDLE;
            end else begin
              phase_q <= byte_w[0] ? PH_RD : PH_REG;
            end
          end
          PH_REG: begin
            ack_q   <= 1'b1;
            phase_q <= PH_WR;
          end
          PH_WR:   ack_q <= 1'b1;
          PH_RD:   ack_q <= 1'b0;
          PH_IDLE: ack_q <= 1'b0;
        endcase
      end
    end else begin
      cnt_q   <= 4'h0;
      ack_q   <= 1'b0;
      first_q <= 1'b0;
      if (rd_go) begin
        tx_q <= regs_rd;
      end else if (phase_q == PH_RD) begin
        phase_q <= PH_IDLE;
      end
    end
  end

  // Pointer survives repeated START; only power-on clears it
  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      ptr_q <= 8'h00;
    end else if (!link_rst_q) begin
      if (byte_end && phase_q == PH_REG) begin
        ptr_q <= byte_w;
      end else if ((byte_end && phase_q == PH_WR) || rd_go) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // Write buffer; core clears valid bits after commit
  always_ff @(posedge scl_clk or posedge buf_clr_q) begin
    if (buf_clr_q) begin
      pend_v_q <= '0;
    end else if (!link_rst_q && byte_end && phase_q == PH_WR) begin
      pend_v_q[ptr_q] <= 1'b1;
    end
  end

  always_ff @(posedge scl_clk) begin
    if (!link_rst_q && byte_end && phase_q == PH_WR) begin
      pend_q[ptr_q] <= byte_w;
    end
  end

  // SDA changes on SCL falling, at the start of the low phase
  always_ff @(negedge scl_clk or posedge link_rst_q) begin
    if (link_rst_q) begin
      drive_low_q <= 1'b0;
    end else begin
      drive_low_q <= (ack_clk & ack_q) |
                     (~ack_clk & (phase_q == PH_RD) & ~tx_q[7]);
    end
  end

  // Open drain: the pin only ever pulls low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign serial_data_pin_out  = sda_o_q;
  assign serial_data_pin_oe_n = ~drive_low_q;

  //////////////////////////////////////////////////////////////////////////////
  // Bank decode: pins act on the outputs; stored registers take them only in ST_CFG
  logic [9:0] ratio_q [4];
  logic [3:0] pecl_q;
  logic [3:0] pinpd_q;
  logic [3:0] pinpd_w;
  logic       frac_q;
  logic       bypass_q;
  logic       single_sel_q;

  assign idx[0] = sel_idx(pins_s2_q[3:2], pins_s2_q[1:0]);
  assign idx[1] = sel_idx(pins_s2_q[7:6], pins_s2_q[5:4]);
  assign idx[2] = sel_idx(pins_s2_q[11:10], pins_s2_q[9:8]);
  assign idx[3] = sel_idx(pins_s2_q[15:14], pins_s2_q[13:12]);

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_bank
      assign pinpd_w[gb] = PD_MASK[gb][idx[gb]];
      // A pin move reaches ratio/type outputs on the third clock edge (two synchroniser flops), output states on the fourth; glitches are the user's risk
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ratio_q[gb] <= 10'h000;
          pecl_q[gb]  <= 1'b0;
          pinpd_q[gb] <= 1'b0;
        end else begin
          ratio_q[gb] <= RATIO_TBL[gb][idx[gb]];
          pecl_q[gb]  <= PECL_MASK[gb][idx[gb]];
          pinpd_q[gb] <= pinpd_w[gb];
        end
      end
    end
  endgenerate

  // Bank D extra modes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frac_q       <= 1'b0;
      bypass_q     <= 1'b0;
      single_sel_q <= 1'b0;
    end else begin
      frac_q       <= D_FRAC_MASK[idx[3]];
      bypass_q     <= D_BYPASS_MASK[idx[3]];
      single_sel_q <= D_SINGLE_MASK[idx[3]];
    end
  end

  assign bank_a_ratio_x4 = ratio_q[0];
  assign bank_b_ratio_x4 = ratio_q[1];
  assign bank_c_ratio_x4 = ratio_q[2];
  assign bank_d_ratio_x4 = ratio_q[3];
  assign bank_pecl       = pecl_q;
  // One swing per bank, taken from the type
  assign bank_a_swing    = pecl_q[0] ? SWING_750MV : SWING_350MV;
  assign bank_b_swing    = pecl_q[1] ? SWING_750MV : SWING_350MV;
  assign bank_c_swing    = pecl_q[2] ? SWING_750MV : SWING_350MV;
  assign bank_d_swing    = pecl_q[3] ? SWING_750MV : SWING_350MV;
  assign bank_d_frac     = frac_q;
  assign bank_d_bypass   = bypass_q;

  //////////////////////////////////////////////////////////////////////////////
  // Output states: power-down wins over disable
  logic [10:0] pd_w;
  logic [10:0] en_w;
  logic [10:0] act_q;
  logic [10:0] true_q;
  logic [10:0] comp_q;

  genvar go;
  generate
    for (go = 0; go < NUM_DIFF; go++) begin : g_out
      assign pd_w[go] = pinpd_q[OUT_BANK[go]] | regs_q[BANK_CTL[OUT_BANK[go]]][PD_BIT] |
                        regs_q[OUT_REG[go]][PD_BIT];
      assign en_w[go] = regs_q[REG_ENABLE][OUT_BANK[go]];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          act_q[go]  <= 1'b1;
          true_q[go] <= 1'b0;
          comp_q[go] <= 1'b1;
        end else begin
          act_q[go]  <= ~run | (~pd_w[go] & en_w[go]);
          true_q[go] <= run & pd_w[go];
          comp_q[go] <= 1'b1;
        end
      end
    end
  endgenerate

  assign diff_active = act_q;
  assign diff_true   = true_q;
  assign diff_comp   = comp_q;

  // Single-ended bank D output
  logic s_pd_w;
  logic s_act_q;
  logic s_oe_n_q;

  assign s_pd_w = ~single_sel_q | regs_q[BANK_CTL[3]][PD_BIT] | regs_q[REG_SINGLE][PD_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_act_q  <= 1'b1;
      s_oe_n_q <= 1'b0;
    end else begin
      s_act_q  <= ~run | (~s_pd_w & regs_q[REG_ENABLE][3]);
      s_oe_n_q <= run & s_pd_w;
    end
  end

  assign bank_d_single_active = s_act_q;
  assign bank_d_single_out    = sda_o_q; // Low whenever not clocking
  assign bank_d_single_oe_n   = s_oe_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // Lock status; cleared until configuration is done
  logic lock_q;
  logic lock_en_q;
  logic ready_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_q    <= 1'b0;
      lock_en_q <= 1'b0;
      ready_q   <= 1'b0;
    end else begin
      lock_q    <= run & lock_s2_q;
      lock_en_q <= run;
      ready_q   <= run;
    end
  end

  assign lock_status     = lock_q;
  assign pll_lock_enable = lock_en_q;
  assign serial_ready    = ready_q;

endmodule
`default_nettype wire

// [pkg/clockgen_pkg.sv]
/*
 Constants for the clock generator control block: pin decode tables, register
 layout, reset values, I2C address and start-up timing.
 Assumes a 100 MHz core clock and an I2C master clocking the bus on its SCL.
*/
// What this block does
// - Pins act directly on outputs; stored registers take pin codes only at configuration.
// - Register bits power down and disable banks; all enabled by default.
// - Disabled: legs low/high, single low. Powered down: legs high, single floats.
// - Each output in a bank has its own power-down bit.
// - Bank A pins pick PECL 16/20/25/100, power-down, LVDS 16/20/25/50.
// - Bank B pins decode exactly like bank A.
// - Bank C pins pick PECL 8/16/20/100, power-down, LVDS 20/25/50/100.
// - Bank D pins pick LVDS, fractional, power-down, single-ended, or bypass modes.
// - Pin control gives a whole bank one setup; PECL 750 mV, LVDS 350 mV.
// - Internal power-on reset lasts at most 175 ms.
// - During power-on reset: defaults held, outputs enabled, lock cleared.
// - Serial port ignores all cycles during power-on reset.
// - After power-on reset registers load defaults mixed with pin states.
// - Serial access and PLL lock attempt start only after configuration.
// - Slave answers at fixed 7-bit address 1101100b.
// - Standard and fast bus rates, master at most 400 kHz.
// - First byte after address is the starting register pointer.
// - Block transfers step upward, each byte MSB first.
// - Master may stop after any complete byte.
// - Written bytes are buffered and all committed together at STOP.
// - A pin change during operation is applied at once and may glitch.
package clockgen_pkg;
  localparam logic [6:0] I2C_ADDR   = 7'h6c;
  localparam int unsigned POR_TIME_MS = 32'h0000_00af; // 175 ms
  localparam int unsigned CLK_KHZ    = 32'h0001_86a0; // 100 MHz
  localparam int unsigned POR_CYCLES = POR_TIME_MS * CLK_KHZ;
  localparam int unsigned POR_W      = 25;
  localparam int unsigned NUM_REGS   = 256;
  localparam int unsigned NUM_DIFF   = 11;
  localparam logic [7:0] REG_ENABLE  = 8'h3d;
  localparam logic [7:0] REG_SINGLE  = 8'h2d;
  localparam int unsigned PD_BIT     = 7;
  localparam logic [1:0] SWING_350MV = 2'h0;
  localparam logic [1:0] SWING_750MV = 2'h2;
  localparam logic [7:0] BANK_BASE [4] = '{8'h10, 8'h18, 8'h20, 8'h28};
  localparam logic [7:0] BANK_CTL  [4] = '{8'h12, 8'h1a, 8'h22, 8'h2a};
  // Divide ratios in quarter units so the fractional bank D ratios fit
  localparam logic [9:0] RATIO_TBL [4][9] = '{
    '{10'h040, 10'h050, 10'h064, 10'h190, 10'h000, 10'h040, 10'h050, 10'h064, 10'h0c8},
    '{10'h040, 10'h050, 10'h064, 10'h190, 10'h000, 10'h040, 10'h050, 10'h064, 10'h0c8},
    '{10'h020, 10'h040, 10'h050, 10'h190, 10'h000, 10'h050, 10'h064, 10'h0c8, 10'h190},
    '{10'h064, 10'h0c8, 10'h04b, 10'h096, 10'h000, 10'h12c, 10'h190, 10'h050, 10'h004}};
  localparam logic [8:0] PECL_MASK [4] = '{9'h00f, 9'h00f, 9'h00f, 9'h000};
  localparam logic [8:0] PD_MASK   [4] = '{9'h010, 9'h010, 9'h010, 9'h030};
  localparam logic [8:0] D_SINGLE_MASK = 9'h120;
  localparam logic [8:0] D_FRAC_MASK   = 9'h00c;
  localparam logic [8:0] D_BYPASS_MASK = 9'h100;
  // Output index to bank and per-output control register
  localparam logic [1:0] OUT_BANK [NUM_DIFF] =
    '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  localparam logic [7:0] OUT_REG [NUM_DIFF] =
    '{8'h14, 8'h15, 8'h16, 8'h17, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h24, 8'h25, 8'h2c};
  // Reset values of the fixed registers
  localparam logic [7:0] DEF_01 = 8'h01;
  localparam logic [7:0] DEF_05 = 8'h19;
  localparam logic [7:0] DEF_08 = 8'h19;
  localparam logic [7:0] DEF_EN = 8'h0f;
  typedef enum logic [1:0] {ST_POR, ST_CFG, ST_RUN} state_t;
  typedef enum logic [2:0] {PH_DEV, PH_REG, PH_WR, PH_RD, PH_IDLE} phase_t;
endpackage

// [testbench/clockgen_ctrl_sva.sv]
/* Port checker: start-up gating, leg levels, pin decode.
 Bound to the block; sees ports only. */
`timescale 1ns/1ps
`default_nettype none
module clockgen_ctrl_sva #(
  parameter int unsigned POR_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        serial_data_pin_oe_n,
  input wire logic [1:0]  bank_c_select_hi,
  input wire logic [1:0]  bank_c_select_lo,
  input wire logic [9:0]  bank_c_ratio_x4,
  input wire logic [9:0]  bank_d_ratio_x4,
  input wire logic [3:0]  bank_pecl,
  input wire logic [1:0]  bank_a_swing,
  input wire logic        bank_d_frac,
  input wire logic        bank_d_bypass,
  input wire logic [10:0] diff_active,
  input wire logic [10:0] diff_comp,
  input wire logic        bank_d_single_active,
  input wire logic        bank_d_single_oe_n,
  input wire logic        pll_lock_enable,
  input wire logic        lock_status,
  input wire logic        serial_ready
);
  import clockgen_pkg::*;
  int unsigned por_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles before the port answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) por_q <= 0;
    else if (!serial_ready) por_q <= por_q + 1;
  end
  //////////////////////////////////////////////////////////////////////
  chk_por_length: assert property ($rose(serial_ready) |-> por_q <= POR_CYCLES + 2)
    else $error("start-up too long");
  chk_por_enabled: assert property (!serial_ready |-> &diff_active)
    else $error("outputs off in start-up");
  chk_ready_lock: assert property ($rose(serial_ready) |-> pll_lock_enable ##1 serial_ready[*4])
    else $error("lock enable late");
  chk_lock_gate: assert property (lock_status |-> pll_lock_enable)
    else $error("early lock status");
  chk_port_quiet: assert property (!serial_ready |-> serial_data_pin_oe_n)
    else $error("pin driven in start-up");
  chk_leg_levels: assert property ((~diff_active & ~diff_comp) == 11'h000)
    else $error("complement leg low");
  chk_single_hiz: assert property (bank_d_single_oe_n |-> !bank_d_single_active)
    else $error("single clocks while floating");
  chk_swing_map: assert property (bank_a_swing == (bank_pecl[0] ? SWING_750MV : SWING_350MV))
    else $error("bank a swing");
  chk_pin_c_low: assert property ((serial_ready && bank_c_select_hi == 2'h0
    && bank_c_select_lo == 2'h0)[*4] |-> bank_c_ratio_x4 == 10'h020 && bank_pecl[2])
    else $error("bank c low code");
  chk_bypass_div: assert property (bank_d_bypass |-> bank_d_ratio_x4 == 10'h004 && !bank_d_frac)
    else $error("bypass ratio");
  chk_frac_div: assert property (bank_d_frac |-> bank_d_ratio_x4 inside {10'h04b, 10'h096})
    else $error("frac ratio");
  cov_ready: cover property ($rose(serial_ready));
  cov_ack: cover property (!serial_data_pin_oe_n);
  cov_bypass: cover property (bank_d_bypass && bank_d_single_active);
endmodule
bind clockgen_ctrl clockgen_ctrl_sva #(.POR_CYCLES(POR_CYCLES)) i_clockgen_ctrl_sva (.clk, .rst,
  .serial_data_pin_oe_n, .bank_c_select_hi, .bank_c_select_lo, .bank_c_ratio_x4,
  .bank_d_ratio_x4, .bank_pecl, .bank_a_swing, .bank_d_frac, .bank_d_bypass, .diff_active,
  .diff_comp, .bank_d_single_active, .bank_d_single_oe_n, .pll_lock_enable, .lock_status,
  .serial_ready);
`default_nettype wire

// [testbench/clockgen_ctrl_tb.sv]
/* Bench: start-up, pin decode, serial port.
 Master model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module clockgen_ctrl_tb;
  import clockgen_pkg::*;
  logic        clk, rst, locked, sda_o, sda_oe_n, scl, m_rel, ack;
  logic        pecl_d, frac, byp, s_act, s_out, s_oen, lk_en, lk, rdy;
  logic [1:0]  sel [8];
  logic [1:0]  sw [4];
  logic [9:0]  rat [4];
  logic [3:0]  pecl;
  logic [10:0] act, tru, cmp;
  logic [19:0] exp_q [$];
  int          miscompares, checks, cyc, seed, pb;
  int          code [4];
  event        pin_ev;
  wire         sda = m_rel & (sda_oe_n | sda_o);
  localparam int FIRST [4] = '{0, 4, 8, 10};
  localparam logic [19:0] DEFS [5] = '{20'h0, 20'h19, 20'h0, 20'h0, 20'h19};
  clockgen_ctrl #(.POR_CYCLES(200)) i_clockgen_ctrl (.clk, .rst, .scl_clk(scl),
    .serial_data_pin_in(sda), .serial_data_pin_out(sda_o), .serial_data_pin_oe_n(sda_oe_n),
    .bank_a_select_hi(sel[1]), .bank_a_select_lo(sel[0]), .bank_b_select_hi(sel[3]),
    .bank_b_select_lo(sel[2]), .bank_c_select_hi(sel[5]), .bank_c_select_lo(sel[4]),
    .bank_d_select_hi(sel[7]), .bank_d_select_lo(sel[6]), .pll_locked_in(locked),
    .bank_a_ratio_x4(rat[0]), .bank_b_ratio_x4(rat[1]), .bank_c_ratio_x4(rat[2]),
    .bank_d_ratio_x4(rat[3]), .bank_pecl(pecl), .bank_a_swing(sw[0]), .bank_b_swing(sw[1]),
    .bank_c_swing(sw[2]), .bank_d_swing(sw[3]), .bank_d_frac(frac), .bank_d_bypass(byp),
    .diff_active(act), .diff_true(tru), .diff_comp(cmp), .bank_d_single_active(s_act),
    .bank_d_single_out(s_out), .bank_d_single_oe_n(s_oen), .pll_lock_enable(lk_en),
    .lock_status(lk), .serial_ready(rdy));
  i2c_mst i_i2c_mst (.scl, .sda_rel(m_rel), .sda);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  // Expected decode word; power-down is both legs high
  function automatic logic [19:0] pin_exp(int b, int c);
    logic p;
    p = (b < 3) && (c < 4);
    return {b == 3 && c inside {2, 3}, b == 3 && c == 8, b == 3 && c inside {5, 8},
      RATIO_TBL[b][c], p, p ? SWING_750MV : SWING_350MV, c == 4 || (b == 3 && c == 5)};
  endfunction
  function automatic logic [19:0] pin_obs(int b);
    return {b == 3 && frac, b == 3 && byp, b == 3 && s_act, rat[b], pecl[b], sw[b],
      !act[FIRST[b]] && tru[FIRST[b]] && cmp[FIRST[b]]};
  endfunction
  task automatic take(input string n, input logic [19:0] g);
    logic [19:0] e;
    e = exp_q.pop_front();
    `CMP(n, e, g)
  endtask
  // Watchers: each result takes the oldest note
  always @(pin_ev) take("pins", pin_obs(pb));
  always @(i_i2c_mst.rd_done) take("read", {12'h0, i_i2c_mst.rd_byte});
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Three-level code: index = 3*hi + lo
  task automatic set_code(int b, int c);
    code[b] = c;
    sel[2 * b + 1] = (c / 3 == 0) ? 2'h0 : (c / 3 == 1 ? 2'h1 : 2'h2);
    sel[2 * b] = (c % 3 == 0) ? 2'h0 : (c % 3 == 1 ? 2'h1 : 2'h2);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1, int n);
    i_i2c_mst.start();
    i_i2c_mst.wbyte({I2C_ADDR, 1'b0}, ack);
    `CMP("ack", 1'b1, ack)
    i_i2c_mst.wbyte(p, ack);
    i_i2c_mst.wbyte(d0, ack);
    if (n > 1) i_i2c_mst.wbyte(d1, ack);
    i_i2c_mst.stop();
    tick(8);
  endtask
  // Pointer, repeated START, n bytes, NACK last
  task automatic rd(input logic [7:0] p, int n, logic skip);
    i_i2c_mst.start();
    i_i2c_mst.wbyte({I2C_ADDR, 1'b0}, ack);
    i_i2c_mst.wbyte(p, ack);
    i_i2c_mst.start();
    i_i2c_mst.wbyte({I2C_ADDR, 1'b1}, ack);
    for (int i = 0; i < n; i++) i_i2c_mst.rbyte(i == n - 1, !(skip && i == 0));
    i_i2c_mst.stop();
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h1020;
    {rst, locked, cyc, checks, miscompares} = {2'b11, 96'h0};
    set_code(0, 7);
    set_code(1, 1);
    set_code(2, 5);
    set_code(3, 0);
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    // Address sent during start-up goes unanswered, lock still cleared
    i_i2c_mst.start();
    i_i2c_mst.wbyte({I2C_ADDR, 1'b0}, ack);
    `CMP("por ack", 1'b0, ack)
    `CMP("por lock", 1'b0, lk)
    i_i2c_mst.stop();
    for (int i = 0; i < 400 && rdy !== 1'b1; i++) tick(1);
    tick(3);
    `CMP("lock", 1'b1, lk)
    foreach (DEFS[i]) exp_q.push_back(DEFS[i]);
    rd(8'h04, 5, 1'b0);
    exp_q.push_back(20'h0);
    exp_q.push_back(20'h1);
    rd(8'hff, 3, 1'b1);
    // All codes, then random mixes
    for (int it = 0; it < 18; it++) begin
      for (int b = 0; b < 4; b++) set_code(b, it < 9 ? it : $unsigned($random(seed)) % 9);
      tick(4);
      for (int b = 0; b < 4; b++) begin
        pb = b;
        exp_q.push_back(pin_exp(b, code[b]));
        -> pin_ev;
        #1;
      end
    end
    exp_q.push_back(20'h7);
    rd(8'h10, 1, 1'b0);
    for (int b = 0; b < 4; b++) set_code(b, 0);
    // Bank power-down must wait for STOP
    i_i2c_mst.start();
    i_i2c_mst.wbyte({I2C_ADDR, 1'b0}, ack);
    i_i2c_mst.wbyte(8'h12, ack);
    i_i2c_mst.wbyte(8'h80, ack);
    tick(20);
    `CMP("pd early", 4'hf, act[3:0])
    i_i2c_mst.stop();
    tick(8);
    `CMP("pd legs", 12'h0ff, {act[3:0], tru[3:0], cmp[3:0]})
    wr(8'h12, 8'h00, 8'h00, 1);
    wr(8'h3d, 8'h0e, 8'h00, 1);
    `CMP("dis legs", 16'hf00f, {act[7:0], tru[3:0], cmp[3:0]})
    wr(8'h3d, 8'h0f, 8'h00, 1);
    wr(8'h14, 8'h00, 8'h80, 2);
    `CMP("out pd", 4'hd, act[3:0])
    i_i2c_mst.start();
    i_i2c_mst.wbyte({I2C_ADDR ^ 7'h01, 1'b0}, ack);
    `CMP("bad addr", 1'b0, ack)
    i_i2c_mst.stop();
    tick(5);
    `CMP("notes left", 0, exp_q.size())
    conclude();
  end
endmodule
`undef CMP
`default_nettype wire

// [testbench/i2c_mst.sv]
/* I2C master model: SCL and open-drain SDA.
 Bench pulls SDA up; SCL idles high. */
`timescale 1ns/1ps
`default_nettype none
module i2c_mst (
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  logic [7:0] rd_byte;
  event       rd_done;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // One bit at a 64 ns period, sampled high phase
  task automatic bit_x(input logic b, output logic r);
    #4 sda_rel = b;
    #28 scl = 1'b1;
    #16 r = sda;
    #16 scl = 1'b0;
  endtask
  // Long low after the fall so the frame reset lands first
  task automatic start();
    #4 sda_rel = 1'b1;
    #28 scl = 1'b1;
    #64 sda_rel = 1'b0;
    #100 scl = 1'b0;
    #100;
  endtask
  task automatic stop();
    #4 sda_rel = 1'b0;
    #28 scl = 1'b1;
    #100 sda_rel = 1'b1;
    #100;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // NACK on the last byte ends the block cleanly
  task automatic rbyte(input logic last, input logic rep);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      rd_byte[i] = r;
    end
    bit_x(last, r);
    if (rep) -> rd_done;
  endtask
endmodule
`default_nettype wire
